// >>> prp_pkg.sv
`default_nettype none
package prp_pkg;
    // --------------------------------------------------------------
    // Serial word and register select
    // --------------------------------------------------------------
    localparam int          WORD_W      = 32;
    localparam int          SEL_MSB     = 3;
    localparam logic [3:0]  SEL_REG0    = 4'h0;
    localparam logic [3:0]  SEL_REG1    = 4'h1;
    localparam logic [3:0]  SEL_REG2    = 4'h2;
    localparam logic [3:0]  SEL_REG4    = 4'h4;
    localparam logic [3:0]  SEL_REG6    = 4'h6;
    localparam logic [3:0]  SEL_REG10   = 4'ha;
    localparam logic [3:0]  SEL_REG11   = 4'hb;
    localparam logic [3:0]  SEL_RESYNC  = 4'hc;
    localparam logic [3:0]  SEL_AUXHI   = 4'hd;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int INT_LSB       = 4;
    localparam int INT_W         = 16;
    localparam int AUTOCAL_BIT   = 21;
    localparam int MAIN_FRACTION_LSB     = 4;
    localparam int MAIN_FRACTION_W       = 24;
    localparam int AUXF_LSB      = 18;
    localparam int AUXM_LSB      = 4;
    localparam int AUX_HALF_W    = 14;
    localparam int AUX_W         = 28;
    localparam int RDIV_LSB      = 15;
    localparam int RDIV_W        = 10;
    localparam int DIV2_BIT      = 25;
    localparam int DOUBLER_BIT   = 26;
    localparam int RFDIV_LSB     = 21;
    localparam int RFDIV_W       = 3;
    localparam int ADCDIV_LSB    = 6;
    localparam int ADCDIV_W      = 8;
    localparam int BAND_HOLD_BIT = 24;
    localparam int RESYNC_LSB    = 12;
    localparam int RESYNC_W      = 20;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [WORD_W-1:0]   WORD_RST   = 32'h0000_0000;
    localparam logic [RDIV_W-1:0]   RDIV_RST   = 10'h001;
    localparam logic [RESYNC_W-1:0] RESYNC_RST = 20'h00001;
    localparam logic [3:0]          PIN_IDLE_RST = 4'h6;
endpackage : prp_pkg
`default_nettype wire

// >>> prp_core.sv
// Operation
// - Band hold keeps VCO core through counter reset
// - Select 1100 loads resync register
// - Resync value sets PFD-period timeout counter
// - Select 1101 loads auxiliary high-half register
// - Aux fraction is high shifted plus low
// - Aux modulus is high shifted plus low
// - Zero high halves behave like low-only part
// - New frequency applies only on register 0
// - Output words feed the frequency equation
// - PFD is reference times doubler over divides
// - Divide-by-two gives 50% comparison clock
// - ADC clock is PFD divided by divider
`default_nettype none
module prp_core (
    input  wire logic                               clock_in,
    input  wire logic                               arst_n_in,
    input  wire logic                               ce_in,
    input  wire logic                               ser_clk_in,
    input  wire logic                               ser_data_in,
    input  wire logic                               ser_load_in,
    input  wire logic                               ref_in,
    input  wire logic                               counter_reset_in,
    output logic [prp_pkg::INT_W-1:0]               int_value_out,
    output logic [prp_pkg::MAIN_FRACTION_W-1:0]             main_fraction_out,
    output logic [prp_pkg::AUX_W-1:0]               aux_fraction_out,
    output logic [prp_pkg::AUX_W-1:0]               aux_modulus_out,
    output logic [prp_pkg::RFDIV_W-1:0]             rf_divider_out,
    output logic                                    autocal_out,
    output logic                                    freq_update_out,
    output logic                                    pfd_tick_out,
    output logic                                    pfd_clk_out,
    output logic                                    adc_tick_out,
    output logic                                    resync_out,
    output logic                                    vco_core_reset_out,
    output logic                                    vco_band_hold_bit_out
);
    // --------------------------------------------------------------
    // Reset release
    // --------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    // Bit order: 0 serial clock, 1 data, 2 load, 3 reference
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] stable_reg;
    logic [3:0] stable_next;
    logic [3:0] pins;
    logic       sclk_rise;
    logic       load_rise;
    logic       ref_rise;
    logic       ref_fall;
    assign pins = {ref_in, ser_load_in, ser_data_in, ser_clk_in};
    // Idle levels at reset, so release never shows a false load edge
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg     <= prp_pkg::PIN_IDLE_RST;
            s2_reg     <= prp_pkg::PIN_IDLE_RST;
            s3_reg     <= prp_pkg::PIN_IDLE_RST;
            stable_reg <= prp_pkg::PIN_IDLE_RST;
        end else if (ce_in) begin
            s1_reg     <= pins;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            stable_reg <= stable_next;
        end
    end
    function automatic logic rose(input logic now, input logic prev);
        rose = now & ~prev;
    endfunction
    // A change counts once the last two stages agree
    always_comb begin
        stable_next = stable_reg;
        for (int i = 0; i < 4; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                stable_next[i] = s3_reg[i];
            end
        end
    end
    assign sclk_rise = ce_in & rose(stable_next[0], stable_reg[0]);
    assign load_rise = ce_in & rose(stable_next[2], stable_reg[2]);
    assign ref_rise  = ce_in & rose(stable_next[3], stable_reg[3]);
    assign ref_fall  = ce_in & rose(stable_reg[3], stable_next[3]);

    // --------------------------------------------------------------
    // Serial shift and latch
    // --------------------------------------------------------------
    logic [prp_pkg::WORD_W-1:0] shift_reg;
    logic [3:0]                 sel;
    logic                       wr0;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= prp_pkg::WORD_RST;
        end else if (sclk_rise && !stable_reg[2]) begin
            shift_reg <= {shift_reg[prp_pkg::WORD_W-2:0], stable_reg[1]};
        end
    end
    assign sel = shift_reg[prp_pkg::SEL_MSB:0];
    assign wr0 = load_rise && sel == prp_pkg::SEL_REG0;
    // Copies of the written registers; frequency fields stay pending until register 0
    logic [prp_pkg::WORD_W-1:0] reg1_reg;
    logic [prp_pkg::WORD_W-1:0] reg2_reg;
    logic [prp_pkg::WORD_W-1:0] reg4_reg;
    logic [prp_pkg::WORD_W-1:0] reg6_reg;
    logic [prp_pkg::WORD_W-1:0] reg10_reg;
    logic [prp_pkg::WORD_W-1:0] reg11_reg;
    logic [prp_pkg::WORD_W-1:0] phase_resync_config_reg;
    logic [prp_pkg::WORD_W-1:0] aux_high_halves_reg;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg1_reg                <= prp_pkg::WORD_RST;
            reg2_reg                <= prp_pkg::WORD_RST;
            reg4_reg                <= prp_pkg::WORD_RST;
            reg6_reg                <= prp_pkg::WORD_RST;
            reg10_reg               <= prp_pkg::WORD_RST;
            reg11_reg               <= prp_pkg::WORD_RST;
            phase_resync_config_reg <= prp_pkg::WORD_RST;
            aux_high_halves_reg     <= prp_pkg::WORD_RST;
        end else if (load_rise) begin
            case (sel)
                prp_pkg::SEL_REG1:   reg1_reg  <= shift_reg;
                prp_pkg::SEL_REG2:   reg2_reg  <= shift_reg;
                prp_pkg::SEL_REG4:   reg4_reg  <= shift_reg;
                prp_pkg::SEL_REG6:   reg6_reg  <= shift_reg;
                prp_pkg::SEL_REG10:  reg10_reg <= shift_reg;
                prp_pkg::SEL_REG11:  reg11_reg <= shift_reg;
                prp_pkg::SEL_RESYNC: phase_resync_config_reg <= shift_reg;
                prp_pkg::SEL_AUXHI:  aux_high_halves_reg <= shift_reg;
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Active settings, taken on register 0
    // --------------------------------------------------------------
    logic [prp_pkg::RDIV_W-1:0] rdiv_reg;
    logic                       doubler_reg;
    logic                       div2_reg;
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            int_value_out     <= '0;
            main_fraction_out <= '0;
            aux_fraction_out  <= '0;
            aux_modulus_out   <= '0;
            rf_divider_out    <= '0;
            autocal_out       <= 1'b0;
            rdiv_reg          <= prp_pkg::RDIV_RST;
            doubler_reg       <= 1'b0;
            div2_reg          <= 1'b0;
        end else if (wr0) begin
            int_value_out     <= shift_reg[prp_pkg::INT_LSB +: prp_pkg::INT_W];
            autocal_out       <= shift_reg[prp_pkg::AUTOCAL_BIT];
            main_fraction_out <=
                reg1_reg[prp_pkg::MAIN_FRACTION_LSB +: prp_pkg::MAIN_FRACTION_W];
            // High half above low half; zero high gives legacy value
            aux_fraction_out <= {
                aux_high_halves_reg[prp_pkg::AUXF_LSB +: prp_pkg::AUX_HALF_W],
                reg2_reg[prp_pkg::AUXF_LSB +: prp_pkg::AUX_HALF_W]};
            aux_modulus_out <= {
                aux_high_halves_reg[prp_pkg::AUXM_LSB +: prp_pkg::AUX_HALF_W],
                reg2_reg[prp_pkg::AUXM_LSB +: prp_pkg::AUX_HALF_W]};
            rf_divider_out <= reg6_reg[prp_pkg::RFDIV_LSB +: prp_pkg::RFDIV_W];
            rdiv_reg       <= reg4_reg[prp_pkg::RDIV_LSB +: prp_pkg::RDIV_W];
            doubler_reg    <= reg4_reg[prp_pkg::DOUBLER_BIT];
            div2_reg       <= reg4_reg[prp_pkg::DIV2_BIT];
        end
    end
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            freq_update_out <= 1'b0;
        end else if (ce_in) begin
            freq_update_out <= wr0;
        end
    end
    // --------------------------------------------------------------
    // Reference path to PFD
    // --------------------------------------------------------------
    logic                       ref_tick;
    logic [prp_pkg::RDIV_W-1:0] rcnt_reg;
    logic                       rdiv_wrap;
    logic                       half_reg;
    // Doubler counts both reference edges
    assign ref_tick  = ref_rise | (doubler_reg & ref_fall);
    assign rdiv_wrap = ref_tick &&
                       (rdiv_reg <= 10'h001 || rcnt_reg >= rdiv_reg - 10'h001);
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_reg <= '0;
            half_reg <= 1'b0;
        end else if (ce_in && (counter_reset_in || wr0)) begin
            rcnt_reg <= '0;
            half_reg <= 1'b0;
        end else if (ref_tick) begin
            rcnt_reg <= rdiv_wrap ? '0 : rcnt_reg + 10'h001;
            if (rdiv_wrap) begin
                half_reg <= ~half_reg;
            end
        end
    end
    logic pfd_tick;
    assign pfd_tick = rdiv_wrap & (~div2_reg | half_reg);
    // Clock level toggles each divider wrap when halving: even duty
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pfd_clk_out  <= 1'b0;
            pfd_tick_out <= 1'b0;
        end else if (ce_in) begin
            pfd_tick_out <= pfd_tick;
            if (div2_reg ? rdiv_wrap : pfd_tick) begin
                pfd_clk_out <= ~pfd_clk_out;
            end
        end
    end
    // --------------------------------------------------------------
    // ADC clock
    // --------------------------------------------------------------
    logic [prp_pkg::ADCDIV_W-1:0] adc_div;
    logic [prp_pkg::ADCDIV_W-1:0] adc_cnt_reg;
    logic                         adc_wrap;
    assign adc_div  = reg10_reg[prp_pkg::ADCDIV_LSB +: prp_pkg::ADCDIV_W];
    assign adc_wrap = pfd_tick &&
                      (adc_div <= 8'h01 || adc_cnt_reg >= adc_div - 8'h01);
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            adc_cnt_reg  <= '0;
            adc_tick_out <= 1'b0;
        end else if (ce_in) begin
            adc_tick_out <= adc_wrap;
            if (pfd_tick) begin
                adc_cnt_reg <= adc_wrap ? '0 : adc_cnt_reg + 8'h01;
            end
        end
    end

    // --------------------------------------------------------------
    // Phase resynchronization timer
    // --------------------------------------------------------------
    // Timing must be chosen by software to land after lock
    logic [prp_pkg::RESYNC_W-1:0] rs_cnt_reg;
    logic                         rs_run_reg;
    logic [prp_pkg::RESYNC_W-1:0] rs_limit;
    assign rs_limit =
        phase_resync_config_reg[prp_pkg::RESYNC_LSB +: prp_pkg::RESYNC_W];
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            rs_cnt_reg <= '0;
            rs_run_reg <= 1'b0;
            resync_out <= 1'b0;
        end else if (ce_in) begin
            resync_out <= 1'b0;
            if (wr0) begin
                rs_cnt_reg <= '0;
                rs_run_reg <= 1'b1;
            end else if (rs_run_reg && pfd_tick) begin
                rs_cnt_reg <= rs_cnt_reg + 20'h00001;
                if (rs_cnt_reg + 20'h00001 >= rs_limit) begin
                    rs_run_reg <= 1'b0;
                    resync_out <= 1'b1;
                end
            end
        end
    end
    // --------------------------------------------------------------
    // Counter reset and band hold
    // --------------------------------------------------------------
    assign vco_band_hold_bit_out = reg11_reg[prp_pkg::BAND_HOLD_BIT];
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            vco_core_reset_out <= 1'b0;
        end else if (ce_in) begin
            vco_core_reset_out <= counter_reset_in & ~vco_band_hold_bit_out;
        end
    end
endmodule : prp_core
`default_nettype wire

// >>> prp_core_checker.sv
`default_nettype none
module prp_core_checker (
    input wire logic                         clock_in,
    input wire logic                         arst_n_in,
    input wire logic                         ce_in,
    input wire logic                         ser_load_in,
    input wire logic                         counter_reset_in,
    input wire logic [prp_pkg::INT_W-1:0]    int_value_out,
    input wire logic [prp_pkg::MAIN_FRACTION_W-1:0]  main_fraction_out,
    input wire logic [prp_pkg::AUX_W-1:0]    aux_fraction_out,
    input wire logic [prp_pkg::AUX_W-1:0]    aux_modulus_out,
    input wire logic [prp_pkg::RFDIV_W-1:0]  rf_divider_out,
    input wire logic                         autocal_out,
    input wire logic                         freq_update_out,
    input wire logic                         pfd_tick_out,
    input wire logic                         adc_tick_out,
    input wire logic                         resync_out,
    input wire logic                         vco_core_reset_out,
    input wire logic                         vco_band_hold_bit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------
    // Port relations
    // ----------------------------------------------
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);

    chk_core_reset_kept: assert property (
        ce_in |=> vco_core_reset_out ==
            $past(counter_reset_in && !vco_band_hold_bit_out))
        else $error("core reset ignores band hold");
    chk_word_applied: assert property (
        ($changed(int_value_out) || $changed(autocal_out) ||
         $changed(rf_divider_out)) |-> freq_update_out)
        else $error("active word changed without update");
    chk_aux_applied: assert property (
        ($changed(aux_fraction_out) || $changed(aux_modulus_out) ||
         $changed(main_fraction_out)) |-> freq_update_out)
        else $error("fraction changed without update");
    chk_update_pulse: assert property (
        freq_update_out |=> !freq_update_out)
        else $error("update pulse too long");
    chk_update_on_load: assert property (
        freq_update_out |-> ser_load_in)
        else $error("update while shifting");
    chk_pfd_pulse: assert property (
        pfd_tick_out |=> !pfd_tick_out)
        else $error("pfd tick too long");
    // Both taps follow a pfd event; either launch latency is accepted
    chk_adc_on_pfd: assert property (
        adc_tick_out |-> pfd_tick_out || $past(pfd_tick_out))
        else $error("adc tick without pfd tick");
    chk_resync_on_pfd: assert property (
        resync_out |-> (pfd_tick_out || $past(pfd_tick_out)) ##1 !resync_out)
        else $error("resync pulse off the pfd count");
endmodule // prp_core_checker
`default_nettype wire

// >>> prp_host_model.sv
`default_nettype none
module prp_host_model (
    input  wire logic clock_in,
    output var  logic ser_clk_out,
    output var  logic ser_data_out,
    output var  logic ser_load_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b1;
        ser_load_out = 1'b1;
    end
    // ----------------------------------------------
    // Word shifter, clock idles low between words
    // ----------------------------------------------
    // Unused resync: value 1, reserved byte 0101_1111
    // Caller picks a count landing after lock
    function automatic logic [31:0] resync_word(input logic [19:0] v);
        return {v, 8'h5f, 4'hc};
    endfunction
    task automatic send(input logic [31:0] w);
        @(posedge clock_in);
        #1 ser_load_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            ser_data_out = w[i];
            repeat (4) @(posedge clock_in);
            #1 ser_clk_out = 1'b1;
            repeat (4) @(posedge clock_in);
            #1 ser_clk_out = 1'b0;
        end
        repeat (4) @(posedge clock_in);
        #1 ser_load_out = 1'b1;
        // Released line shows the inverse, never a stale copy
        ser_data_out = ~w[0];
        repeat (12) @(posedge clock_in);
    endtask
endmodule // prp_host_model
`default_nettype wire

// >>> pll_register_programming_test.sv
`default_nettype none
module pll_register_programming_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock_in, arst_n_in, ref_in, counter_reset_in, ce_in;
    logic        ser_clk, ser_data, ser_load, autocal_out;
    logic        freq_update_out, pfd_tick_out, pfd_clk_out;
    logic        adc_tick_out, resync_out, vco_core_reset_out;
    logic        vco_band_hold_bit_out;
    logic [15:0] int_value_out;
    logic [23:0] main_fraction_out;
    logic [27:0] aux_fraction_out, aux_modulus_out;
    logic [2:0]  rf_divider_out;
    int          err_total, compares, n_upd, n_pfd, n_adc, n_pclk;
    int          since, resync_at;
    logic        pclk_d;

    prp_host_model u_host (.clock_in(clock_in), .ser_clk_out(ser_clk),
        .ser_data_out(ser_data), .ser_load_out(ser_load));
    prp_core u_dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .ce_in(ce_in), .ser_clk_in(ser_clk), .ser_data_in(ser_data),
        .ser_load_in(ser_load), .ref_in(ref_in),
        .counter_reset_in(counter_reset_in),
        .int_value_out(int_value_out),
        .main_fraction_out(main_fraction_out),
        .aux_fraction_out(aux_fraction_out),
        .aux_modulus_out(aux_modulus_out),
        .rf_divider_out(rf_divider_out), .autocal_out(autocal_out),
        .freq_update_out(freq_update_out), .pfd_tick_out(pfd_tick_out),
        .pfd_clk_out(pfd_clk_out), .adc_tick_out(adc_tick_out),
        .resync_out(resync_out), .vco_core_reset_out(vco_core_reset_out),
        .vco_band_hold_bit_out(vco_band_hold_bit_out));

    // ----------------------------------------------
    // Clocks, monitors, helpers
    // ----------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        ref_in = 1'b0;
        forever begin
            repeat (4) @(posedge clock_in);
            #1 ref_in = ~ref_in;
        end
    end
    always @(posedge clock_in) begin
        n_upd += (freq_update_out === 1'b1);
        n_pfd += (pfd_tick_out === 1'b1);
        n_adc += (adc_tick_out === 1'b1);
        n_pclk += (pfd_clk_out !== pclk_d);
        pclk_d = pfd_clk_out;
        if (freq_update_out === 1'b1) since = 0;
        else since += (pfd_tick_out === 1'b1);
        if (resync_out === 1'b1) resync_at = since;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic check_val(input string n, input logic [31:0] e,
                             input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_near(input string n, input int e, input int g);
        compares++;
        if (g < e - 1 || g > e + 1) begin
            err_total++;
            $display("Error %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic send0(input logic ac); // integer 68
        int u;
        u = n_upd;
        u_host.send(32'h0000_0440 | 32'(ac) << prp_pkg::AUTOCAL_BIT);
        check_val("update count", 32'(u + 1), 32'(n_upd));
    endtask
    task automatic wait_adc(input int n);
        int a;
        a = n_adc;
        for (int k = 0; k < 4000 && n_adc < a + n; k++) tick(1);
        check_near("adc wait", a + n, n_adc);
    endtask

    // ----------------------------------------------
    // Scenarios
    // ----------------------------------------------
    task automatic t_powerup();
        for (int s = 13; s >= 1; s--) begin
            if (s == 12) u_host.send(u_host.resync_word(20'h00001));
            else if (s == 10) u_host.send(32'h00c0_008a);
            else if (s == 4) u_host.send(32'h0000_8004);
            else if (s == 6) u_host.send(32'h0040_0006);
            else u_host.send(32'(s));
        end
        check_val("int pending", 0, 32'(int_value_out));
        wait_adc(17);
        send0(1'b1);
        check_val("int", 32'h44, 32'(int_value_out));
        check_val("autocal", 1, 32'(autocal_out));
        check_val("rf div", 2, 32'(rf_divider_out));
    endtask
    task automatic t_aux(input logic [13:0] hf, input logic [13:0] hm,
                         input logic [27:0] pf);
        u_host.send({hf, hm, 4'hd});
        u_host.send(32'h00c0_008a);
        u_host.send({14'h0400, 14'h0600, 4'h2});
        u_host.send({4'h0, 24'hc6aaaa, 4'h1});
        check_val("aux pending", 32'(pf), 32'(aux_fraction_out));
        wait_adc(17);
        send0(1'b0);
        check_val("aux frac", {hf, 14'h0400}, 32'(aux_fraction_out));
        check_val("aux mod", {hm, 14'h0600}, 32'(aux_modulus_out));
        check_val("main frac", 24'hc6aaaa, 32'(main_fraction_out));
    endtask
    task automatic t_rates();
        int p, a, c, e;
        int cfg [4][4] = '{'{1,0,0,1}, '{2,0,0,3}, '{1,1,0,2}, '{2,0,1,2}};
        foreach (cfg[i]) begin
            u_host.send(32'h00c0_000a | 32'(cfg[i][3]) << 6);
            u_host.send(32'(cfg[i][0]) << 15 | 32'(cfg[i][1]) << 25 |
                        32'(cfg[i][2]) << 26 | 32'h4);
            wait_adc(17);
            send0(1'b0);
            tick(24);
            p = n_pfd;
            a = n_adc;
            c = n_pclk;
            tick(192);
            e = 24 * (1 + cfg[i][2]) / (cfg[i][0] * (1 + cfg[i][1]));
            check_near("pfd ticks", e, n_pfd - p);
            check_near("adc ticks", e / cfg[i][3], n_adc - a);
            e = 24 * (1 + cfg[i][2]) / cfg[i][0];
            check_near("pfd clock edges", e, n_pclk - c);
        end
    endtask
    task automatic t_fast();
        int p;
        for (int k = 0; k < 2; k++) begin
            u_host.send({14'h0000, 14'h0000, 4'hd});
            if (k == 0) u_host.send(32'h00c0_008a);
            u_host.send(32'(2 - k) << 15 | 32'h4);
            u_host.send({14'h0400, 14'h0600, 4'h2});
            u_host.send({4'h0, 24'hc6aaaa, 4'h1});
            if (k == 0) wait_adc(17);
            send0(k == 0);
            check_val("autocal", 32'(k == 0), 32'(autocal_out));
            p = n_pfd;
            tick(192);
            check_near("pfd ticks", 12 * (1 + k), n_pfd - p);
        end
    endtask
    task automatic t_freeze();
        int   p;
        logic c;
        while (pfd_tick_out !== 1'b1) tick(1);
        tick(1);
        ce_in = 1'b0;
        p = n_pfd;
        c = pfd_clk_out;
        tick(100);
        check_val("frozen ticks", 0, 32'(n_pfd - p));
        check_val("frozen clock", 32'(c), 32'(pfd_clk_out));
        ce_in = 1'b1;
        p = n_pfd;
        tick(192);
        check_near("thawed ticks", 24, n_pfd - p);
    endtask
    task automatic t_resync(input logic [19:0] v);
        u_host.send(u_host.resync_word(v));
        resync_at = -1;
        send0(1'b0);
        tick(300);
        check_near("resync ticks", 32'(v), resync_at);
    endtask
    task automatic t_band_hold();
        counter_reset_in = 1'b1;
        tick(3);
        check_val("core reset", 1, 32'(vco_core_reset_out));
        u_host.send(32'h0161_200b);
        check_val("hold", 1, 32'(vco_band_hold_bit_out));
        check_val("core kept", 0, 32'(vco_core_reset_out));
        counter_reset_in = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        {err_total, compares, n_upd, n_pfd, n_adc, n_pclk, since} = '0;
        pclk_d = 1'b0;
        arst_n_in = 1'b0;
        ce_in = 1'b1;
        counter_reset_in = 1'b0;
        tick(6);
        arst_n_in = 1'b1;
        tick(4);
        t_powerup();
        t_aux(14'h2a31, 14'h1c0e, 28'h0);
        t_aux(14'h0000, 14'h0000, {14'h2a31, 14'h0400});
        t_rates();
        t_fast();
        t_resync(20'h00005);
        t_resync(20'h00001);
        t_freeze();
        t_band_hold();
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge clock_in);
        err_total++;
        tally_and_finish();
    end
endmodule // pll_register_programming_test

bind prp_core prp_core_checker u_chk (.clock_in(clock_in),
    .arst_n_in(arst_n_in), .ce_in(ce_in), .ser_load_in(ser_load_in),
    .counter_reset_in(counter_reset_in), .int_value_out(int_value_out),
    .main_fraction_out(main_fraction_out),
    .aux_fraction_out(aux_fraction_out), .aux_modulus_out(aux_modulus_out),
    .rf_divider_out(rf_divider_out), .autocal_out(autocal_out),
    .freq_update_out(freq_update_out), .pfd_tick_out(pfd_tick_out),
    .adc_tick_out(adc_tick_out), .resync_out(resync_out),
    .vco_core_reset_out(vco_core_reset_out),
    .vco_band_hold_bit_out(vco_band_hold_bit_out));
`default_nettype wire
